// ==== rtl/tpwm_cfg_cfg.svh ====
// Register map, field positions, reset values and mode codes of the motor PWM block
`ifndef TPWM_CFG_CFG_SVH
`define TPWM_CFG_CFG_SVH
`define TPWM_A_RUN   8'h00
`define TPWM_A_MOD3  8'h04
`define TPWM_A_MOD4  8'h08
`define TPWM_A_OLC   8'h0C
`define TPWM_A_OME   8'h10
`define TPWM_A_BUS1  8'h14
`define TPWM_A_CNT3  8'h18
`define TPWM_A_CNT4  8'h1C
`define TPWM_A_PCMP  8'h20
`define TPWM_A_DC1   8'h24
`define TPWM_A_DC2   8'h28
`define TPWM_A_DC3   8'h2C
`define TPWM_A_PBUF  8'h30
`define TPWM_A_DB1   8'h34
`define TPWM_A_DB2   8'h38
`define TPWM_A_DB3   8'h3C
`define TPWM_A_DEAD  8'h40
`define TPWM_A_CYC   8'h44
`define TPWM_A_CBUF  8'h48
`define TPWM_A_SUB   8'h4C
`define TPWM_B_RUN3  0
`define TPWM_B_RUN4  1
`define TPWM_B_POS_LEVEL_SELECT  0
`define TPWM_B_NEG_LEVEL_SELECT  1
`define TPWM_B_TOGGLE_SYNC_ENABLE  6
`define TPWM_B_WEN   13
`define TPWM_B_TOGOE 6
`define TPWM_M_RSYNC 4'h8
`define TPWM_M_CREST 4'hD
`define TPWM_M_TROUG 4'hE
`define TPWM_M_BOTH  4'hF
`define TPWM_CLR_PER 3'h1
`define TPWM_RV_LIM  16'hFFFF
`define TPWM_RV_ZERO 16'h0000
`endif

// ==== rtl/tpwm_pkg.sv ====
// Types shared by the motor PWM block
package tpwm_pkg;
    typedef enum logic [1:0] {
        TPWM_UP = 2'h1,
        TPWM_DN = 2'h2
    } tpwm_dir_t;
    typedef struct packed {
        logic                 ack;
        logic [31:0]          rdata;
        logic [1:0]           run;
        logic [3:0]           mode3;
        logic [2:0]           clr3;
        logic [3:0]           mode4;
        logic [2:0]           olc;
        logic [6:0]           oer;
        logic                 wen;
        logic [15:0]          cnt3;
        logic [15:0]          cnt4;
        logic [15:0]          per;
        logic [15:0]          pbuf;
        logic [15:0]          ptmp;
        logic [15:0]          cyc;
        logic [15:0]          cbuf;
        logic [15:0]          ctmp;
        logic [15:0]          dead;
        logic [15:0]          sub;
        logic [2:0][15:0]     duty;
        logic [2:0][15:0]     dbuf;
        logic [2:0][15:0]     dtmp;
        tpwm_dir_t            dir;
        logic                 tb;
        logic                 comp_q;
        logic                 pend;
        logic [2:0]           praw;
        logic [2:0]           nraw;
        logic                 tog;
        logic [6:0]           pin;
        logic [6:0]           oe_n;
    } tpwm_state_t;
endpackage

// ==== rtl/tpwm_top.sv ====
// Three-phase motor PWM: reset-sync and complementary modes, Avalon-MM registers
//
// The placing of the registers and the Avalon-MM slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_cfg_cfg.svh"
module tpwm_top
    import tpwm_pkg::*;
(
    // Clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // Avalon-MM slave
    input  wire logic [7:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    // Motor pins
    output logic             toggle_sync_pin,
    output logic             pwm_out1_pos,
    output logic             pwm_out1_neg,
    output logic             pwm_out2_pos,
    output logic             pwm_out2_neg,
    output logic             pwm_out3_pos,
    output logic             pwm_out3_neg,
    // Pin enables, low while driving: 0..5 as above, 6 toggle pin
    output logic [6:0]       pin_oe_n
);
    tpwm_state_t st;
    tpwm_state_t next_st;
    logic        req;
    logic        wr;
    logic        mwr;
    logic        rsync;
    logic        comp;
    logic        comp_run;
    logic        crest;
    logic        trough;
    logic        wrap;

    function automatic logic [15:0] tpwm_merge(input logic [15:0] o,
                                               input logic [31:0] d,
                                               input logic [3:0]  be);
        tpwm_merge = {be[1] ? d[15:8] : o[15:8], be[0] ? d[7:0] : o[7:0]};
    endfunction

    function automatic logic [15:0] tpwm_rd(input tpwm_state_t s,
                                            input logic [7:0]  a);
        logic [15:0] v;
        logic        m;
        v = 16'h0000;
        m = 1'b0;
        case (a)
            `TPWM_A_RUN:  v = {14'h0000, s.run};
            `TPWM_A_MOD3: v = {9'h000, s.clr3, s.mode3};
            `TPWM_A_MOD4: v = {12'h000, s.mode4};
            `TPWM_A_OLC:  v = {9'h000, s.olc[2], 4'h0, s.olc[1:0]};
            `TPWM_A_OME:  v = {9'h000, s.oer};
            `TPWM_A_BUS1: v = {2'h0, s.wen, 13'h0000};
            `TPWM_A_CNT3: begin v = s.cnt3; m = 1'b1; end
            `TPWM_A_CNT4: begin v = s.cnt4; m = 1'b1; end
            `TPWM_A_PCMP: begin v = s.per; m = 1'b1; end
            `TPWM_A_DC1:  begin v = s.duty[0]; m = 1'b1; end
            `TPWM_A_DC2:  begin v = s.duty[1]; m = 1'b1; end
            `TPWM_A_DC3:  begin v = s.duty[2]; m = 1'b1; end
            `TPWM_A_PBUF: v = s.pbuf;
            `TPWM_A_DB1:  v = s.dbuf[0];
            `TPWM_A_DB2:  v = s.dbuf[1];
            `TPWM_A_DB3:  v = s.dbuf[2];
            `TPWM_A_DEAD: begin v = s.dead; m = 1'b1; end
            `TPWM_A_CYC:  begin v = s.cyc; m = 1'b1; end
            `TPWM_A_CBUF: v = s.cbuf;
            `TPWM_A_SUB:  v = s.sub;
            default:      v = 16'h0000;
        endcase
        // Masked registers read as zero while access is off
        tpwm_rd = (m && !s.wen) ? 16'h0000 : v;
    endfunction

    // One wait state: request taken at the edge where waitrequest is low
    assign req             = avs_read | avs_write;
    assign avs_waitrequest = req & ~st.ack;
    assign wr              = avs_write & st.ack;
    assign mwr             = wr & st.wen;
    assign avs_readdata    = st.rdata;

    assign rsync    = st.mode3 == `TPWM_M_RSYNC;
    assign comp     = st.mode3 == `TPWM_M_CREST || st.mode3 == `TPWM_M_TROUG ||
                      st.mode3 == `TPWM_M_BOTH;
    assign comp_run = comp & st.run[`TPWM_B_RUN3] & st.run[`TPWM_B_RUN4];
    assign wrap     = rsync & st.run[`TPWM_B_RUN3] & st.cnt3 == st.per &
                      st.clr3 == `TPWM_CLR_PER;
    assign crest    = comp_run & st.dir == TPWM_UP & st.cnt3 == st.per;
    assign trough   = comp_run & st.dir == TPWM_DN & st.cnt3 == st.dead;

    always_comb begin
        logic tb_now;
        logic pos_level_select;
        logic neg_level_select;
        tb_now  = 1'b0;
        next_st = st;
        pos_level_select    = st.olc[`TPWM_B_POS_LEVEL_SELECT];
        neg_level_select    = st.olc[`TPWM_B_NEG_LEVEL_SELECT];
        next_st.ack = req & ~st.ack;
        if (avs_read && !st.ack)
            next_st.rdata = {16'h0000, tpwm_rd(st, avs_address)};

        // Counters
        if (rsync && st.run[`TPWM_B_RUN3]) begin
            if (wrap)
                next_st.cnt3 = 16'h0000;
            else
                next_st.cnt3 = st.cnt3 + 16'h0001;
        end else if (comp && !comp_run) begin
            next_st.cnt3 = st.dead;
            next_st.cnt4 = 16'h0000;
            next_st.dir  = TPWM_UP;
        end else if (comp_run) begin
            // Both counters move together so the dead-time offset holds
            if (crest) begin
                next_st.dir  = TPWM_DN;
                next_st.cnt3 = st.cnt3 - 16'h0001;
                next_st.cnt4 = st.cnt4 - 16'h0001;
            end else if (trough) begin
                next_st.dir  = TPWM_UP;
                next_st.cnt3 = st.cnt3 + 16'h0001;
                next_st.cnt4 = st.cnt4 + 16'h0001;
            end else if (st.dir == TPWM_UP) begin
                next_st.cnt3 = st.cnt3 + 16'h0001;
                next_st.cnt4 = st.cnt4 + 16'h0001;
            end else begin
                next_st.cnt3 = st.cnt3 - 16'h0001;
                next_st.cnt4 = st.cnt4 - 16'h0001;
            end
        end

        // Tb interval around crest and trough; subcounter runs only there
        tb_now     = comp_run & (st.cnt3 > st.cyc | st.cnt4 < st.dead);
        next_st.tb = tb_now;
        if (tb_now && !st.tb)
            next_st.sub = (st.dir == TPWM_UP) ? st.cyc : st.dead;
        else if (tb_now)
            next_st.sub = (st.dir == TPWM_UP) ? st.sub + 16'h0001 :
                                                st.sub - 16'h0001;

        // Buffer to temporary, all five at once, held off during Tb
        if (st.pend && !tb_now) begin
            next_st.ptmp = st.pbuf;
            next_st.ctmp = st.cbuf;
            next_st.dtmp = st.dbuf;
            next_st.pend = 1'b0;
        end
        // Temporary to compare at the selected turning point
        if ((crest && st.mode3 != `TPWM_M_TROUG) ||
            (trough && st.mode3 != `TPWM_M_CREST)) begin
            next_st.per  = st.ptmp;
            next_st.cyc  = st.ctmp;
            next_st.duty = st.dtmp;
        end
        // Entering complementary mode loads buffers straight through
        next_st.comp_q = comp;
        if (comp && !st.comp_q) begin
            next_st.ptmp = st.pbuf;
            next_st.ctmp = st.cbuf;
            next_st.dtmp = st.dbuf;
            next_st.per  = st.pbuf;
            next_st.cyc  = st.cbuf;
            next_st.duty = st.dbuf;
        end

        // Raw phase waveforms
        for (int i = 0; i < 3; i++) begin
            if (rsync && st.run[`TPWM_B_RUN3]) begin
                if (wrap && st.duty[i] == st.per)
                    next_st.praw[i] = ~st.praw[i];
                else if (wrap)
                    next_st.praw[i] = 1'b1;
                else if (st.cnt3 == st.duty[i])
                    next_st.praw[i] = 1'b0;
                next_st.nraw[i] = ~next_st.praw[i];
            end else if (comp_run) begin
                // Counters differ by the dead time, so both sides are off between
                next_st.praw[i] = st.cnt4 >= st.duty[i];
                next_st.nraw[i] = st.cnt3 < st.duty[i];
            end
        end
        if ((wrap || crest) && st.olc[`TPWM_B_TOGGLE_SYNC_ENABLE])
            next_st.tog = ~st.tog;

        // Phase pins follow the level selects and master enables; the toggle pin follows its enable only
        for (int i = 0; i < 3; i++) begin
            next_st.pin[2*i]   = st.oer[2*i] & (st.praw[i] ^ ~pos_level_select);
            next_st.pin[2*i+1] = st.oer[2*i+1] & (st.nraw[i] ^ ~neg_level_select);
        end
        next_st.pin[6] = st.oer[`TPWM_B_TOGOE] & st.tog;
        for (int i = 0; i < 6; i++)
            next_st.oe_n[i] = ~((rsync | comp) & st.oer[i]);
        next_st.oe_n[6] = ~((rsync | comp) & st.olc[`TPWM_B_TOGGLE_SYNC_ENABLE] &
                            st.oer[`TPWM_B_TOGOE]);

        // Software writes win over hardware updates in the same cycle
        if (wr) begin
            case (avs_address)
                `TPWM_A_RUN:  if (avs_byteenable[0])
                    next_st.run = avs_writedata[1:0];
                `TPWM_A_MOD3: begin
                    next_st.mode3 = avs_byteenable[0] ? avs_writedata[3:0] : st.mode3;
                    next_st.clr3  = avs_byteenable[0] ? avs_writedata[6:4] : st.clr3;
                end
                `TPWM_A_MOD4: if (avs_byteenable[0])
                    next_st.mode4 = avs_writedata[3:0];
                `TPWM_A_OLC:  if (avs_byteenable[0])
                    next_st.olc = {avs_writedata[`TPWM_B_TOGGLE_SYNC_ENABLE], avs_writedata[1:0]};
                `TPWM_A_OME:  if (avs_byteenable[0])
                    next_st.oer = avs_writedata[6:0];
                `TPWM_A_BUS1: if (avs_byteenable[1])
                    next_st.wen = avs_writedata[`TPWM_B_WEN];
                `TPWM_A_PBUF: next_st.pbuf = tpwm_merge(st.pbuf, avs_writedata,
                                                        avs_byteenable);
                `TPWM_A_DB1:  next_st.dbuf[0] = tpwm_merge(st.dbuf[0], avs_writedata,
                                                           avs_byteenable);
                `TPWM_A_DB2:  next_st.dbuf[1] = tpwm_merge(st.dbuf[1], avs_writedata,
                                                           avs_byteenable);
                `TPWM_A_DB3:  begin
                    next_st.dbuf[2] = tpwm_merge(st.dbuf[2], avs_writedata,
                                                 avs_byteenable);
                    next_st.pend    = 1'b1;
                end
                `TPWM_A_CBUF: next_st.cbuf = tpwm_merge(st.cbuf, avs_writedata,
                                                        avs_byteenable);
                default:      next_st.pend = next_st.pend;
            endcase
        end
        // Masked group dropped whole when access is off
        if (mwr) begin
            case (avs_address)
                `TPWM_A_CNT3: next_st.cnt3 = tpwm_merge(st.cnt3, avs_writedata,
                                                        avs_byteenable);
                `TPWM_A_CNT4: next_st.cnt4 = tpwm_merge(st.cnt4, avs_writedata,
                                                        avs_byteenable);
                `TPWM_A_PCMP: next_st.per = tpwm_merge(st.per, avs_writedata,
                                                       avs_byteenable);
                `TPWM_A_DC1:  next_st.duty[0] = tpwm_merge(st.duty[0], avs_writedata,
                                                           avs_byteenable);
                `TPWM_A_DC2:  next_st.duty[1] = tpwm_merge(st.duty[1], avs_writedata,
                                                           avs_byteenable);
                `TPWM_A_DC3:  next_st.duty[2] = tpwm_merge(st.duty[2], avs_writedata,
                                                           avs_byteenable);
                `TPWM_A_DEAD: next_st.dead = tpwm_merge(st.dead, avs_writedata,
                                                        avs_byteenable);
                `TPWM_A_CYC:  next_st.cyc = tpwm_merge(st.cyc, avs_writedata,
                                                       avs_byteenable);
                default:      next_st.cyc = next_st.cyc;
            endcase
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            st      <= '0;
            st.wen  <= 1'b1;
            st.per  <= `TPWM_RV_LIM;
            st.pbuf <= `TPWM_RV_LIM;
            st.ptmp <= `TPWM_RV_LIM;
            st.cyc  <= `TPWM_RV_LIM;
            st.cbuf <= `TPWM_RV_LIM;
            st.ctmp <= `TPWM_RV_LIM;
            st.dead <= `TPWM_RV_ZERO;
            st.dir  <= TPWM_UP;
            st.oe_n <= 7'h7F;
        end else begin
            st <= next_st;
        end
    end

    assign pwm_out1_pos    = st.pin[0];
    assign pwm_out1_neg    = st.pin[1];
    assign pwm_out2_pos    = st.pin[2];
    assign pwm_out2_neg    = st.pin[3];
    assign pwm_out3_pos    = st.pin[4];
    assign pwm_out3_neg    = st.pin[5];
    assign toggle_sync_pin = st.pin[6];
    assign pin_oe_n        = st.oe_n;

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence crest_seq;
        crest ##1 (st.dir == TPWM_DN);
    endsequence

    sequence mask_wr_seq;
        avs_write && st.ack && !st.wen && avs_address == `TPWM_A_DEAD;
    endsequence

    rsync_count_a: assert property (rsync && st.run[0] && !wrap && !wr
        |=> st.cnt3 == $past(st.cnt3) + 16'h0001) else $error("up-count lost");
    rsync_clear_a: assert property (wrap && !wr |=> st.cnt3 == 16'h0000)
        else $error("no clear at period");
    pair_invert_a: assert property (rsync && st.run[0] |=> st.nraw == ~st.praw)
        else $error("negative phase not inverse");
    comp_start_a: assert property (comp && !comp_run && !wr
        |=> st.cnt3 == $past(st.dead) && st.cnt4 == 16'h0000)
        else $error("bad start value");
    crest_turn_a: assert property (crest && !wr |-> crest_seq)
        else $error("no turn at crest");
    dead_offset_a: assert property (comp_run && !wr && !$past(wr) && $past(comp_run)
        |-> st.cnt3 - st.cnt4 == st.dead) else $error("offset lost");
    mask_keep_a: assert property (mask_wr_seq |=> st.dead == $past(st.dead))
        else $error("masked write landed");
    xfer_all_a: assert property (st.pend && !next_st.tb && !(comp && !st.comp_q)
        |=> st.dtmp == $past(st.dbuf) && st.ptmp == $past(st.pbuf))
        else $error("buffer transfer missed");
    pin_level_a: assert property (##1 pwm_out1_pos ==
        ($past(st.oer[0]) & ($past(st.praw[0]) ^ ~$past(st.olc[0]))))
        else $error("level select ignored");
    pin_enable_a: assert property (rsync && st.oer[0] |=> !pin_oe_n[0])
        else $error("pin not driven");
    toggle_a: assert property ((wrap || crest) && st.olc[2]
        |=> st.tog != $past(st.tog)) else $error("sync toggle missing");
endmodule
`default_nettype wire

// ==== test/tpwm_gate_model.sv ====
// Gate driver stand-in: counts shoot-through cycles and toggle pin edges
`timescale 1ns/1ps
`default_nettype none
module tpwm_gate_model (
    // Clock and count clear
    input  wire logic        mclk,
    input  wire logic        clr,
    // Driven gate levels and toggle pin
    input  wire logic [5:0]  gate,
    input  wire logic        tog,
    // Counts
    output logic [15:0]      shoot,
    output logic [15:0]      tog_edges
);
    logic tog_q;
    // Both switches of one leg on shorts the supply
    always_ff @(posedge mclk) begin
        tog_q <= tog;
        if (clr) begin
            shoot <= 16'h0000;
            tog_edges <= 16'h0000;
        end else begin
            if ((gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5])) begin
                shoot <= shoot + 16'h0001;
            end
            if (tog != tog_q) begin
                tog_edges <= tog_edges + 16'h0001;
            end
        end
    end
endmodule
`default_nettype wire

// ==== test/tb_top.sv ====
// Self-checking bench for the motor PWM block
`timescale 1ns/1ps
`default_nettype none
`include "tpwm_cfg_cfg.svh"
module tb_top;
    logic        mclk;
    logic        rst;
    logic [7:0]  avs_address;
    logic        avs_read;
    logic        avs_write;
    logic [31:0] avs_writedata;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic [6:0]  pins;
    logic [6:0]  pin_oe_n;
    logic        clr;
    logic [15:0] shoot;
    logic [15:0] tog_edges;
    int          fails;
    int          checked;
    int          h1, h2, h3, bad;
    logic [31:0] q;

    tpwm_top i_dut (.mclk(mclk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
        .toggle_sync_pin(pins[6]), .pwm_out1_pos(pins[0]), .pwm_out1_neg(pins[1]),
        .pwm_out2_pos(pins[2]), .pwm_out2_neg(pins[3]), .pwm_out3_pos(pins[4]),
        .pwm_out3_neg(pins[5]), .pin_oe_n(pin_oe_n));
    tpwm_gate_model i_gate (.mclk(mclk), .clr(clr), .gate(pins[5:0] & ~pin_oe_n[5:0]),
        .tog(pins[6]), .shoot(shoot), .tog_edges(tog_edges));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    task automatic wrap_up;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        checked++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH t=%0t %s seen %h exp %h", $time, msg, seen, exp);
        end
    endtask

    // One Avalon transfer; held until waitrequest is sampled low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge mclk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        q = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        if (n >= 20) begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string msg);
        bus(1'b0, a, 32'h00000000);
        chk(q, exp, msg);
    endtask

    // High counts per phase and pairs that fail to be complementary
    task automatic watch(input int n);
        h1 = 0; h2 = 0; h3 = 0; bad = 0;
        repeat (n) begin
            @(negedge mclk);
            h1 += int'(pins[0]);
            h2 += int'(pins[2]);
            h3 += int'(pins[4]);
            bad += int'((pins[1] !== ~pins[0]) || (pins[3] !== ~pins[2]) || (pins[5] !== ~pins[4]));
        end
    endtask

    task automatic t_reset_vals;
        rdc(`TPWM_A_PCMP, 32'h0000FFFF, "period reset");
        rdc(`TPWM_A_PBUF, 32'h0000FFFF, "period buffer reset");
        rdc(`TPWM_A_CYC, 32'h0000FFFF, "cycle reset");
        rdc(`TPWM_A_BUS1, 32'h00002000, "write enable reset");
        rdc(8'h80, 32'h00000000, "unmapped read");
        chk({25'h0, pin_oe_n}, 32'h0000007F, "pins released");
    endtask

    task automatic t_rsync;
        wr(`TPWM_A_RUN, 32'h0);
        wr(`TPWM_A_CNT3, 32'h0);
        wr(`TPWM_A_CNT4, 32'h0);
        wr(`TPWM_A_PCMP, 32'h9);
        wr(`TPWM_A_DC1, 32'h3);
        wr(`TPWM_A_DC2, 32'h5);
        wr(`TPWM_A_DC3, 32'h9);
        wr(`TPWM_A_OLC, 32'h3);
        wr(`TPWM_A_OME, 32'h3F);
        wr(`TPWM_A_MOD3, 32'h18);
        wr(`TPWM_A_RUN, 32'h1);
        chk({26'h0, pin_oe_n[5:0]}, 32'h0, "six pins driven");
        // First period starts low; skip it, then ten-cycle period fits the window
        repeat (20) @(posedge mclk);
        watch(100);
        chk(32'(h1), 32'd40, "phase 1 high time");
        chk(32'(h2), 32'd60, "phase 2 high time");
        chk(32'(h3), 32'd50, "phase 3 toggles");
        chk(32'(bad), 32'd0, "negative phases");
        repeat (4) begin
            bus(1'b0, `TPWM_A_CNT3, 32'h0);
            chk({31'h0, q <= 32'h9}, 32'h1, "up count in range");
        end
        wr(`TPWM_A_OME, 32'h3E);
        // Pin register lags the enable by one edge
        @(posedge mclk);
        watch(20);
        chk(32'(h1), 32'd0, "disabled pin held");
    endtask

    task automatic t_mask;
        wr(`TPWM_A_BUS1, 32'h0);
        wr(`TPWM_A_DC1, 32'h1234);
        wr(`TPWM_A_DEAD, 32'h5);
        rdc(`TPWM_A_DC1, 32'h0, "masked read");
        wr(`TPWM_A_PBUF, 32'h7);
        rdc(`TPWM_A_PBUF, 32'h7, "buffer open when masked");
        wr(`TPWM_A_BUS1, 32'h2000);
        rdc(`TPWM_A_DC1, 32'h3, "masked write ignored");
        rdc(`TPWM_A_DEAD, 32'h0, "masked dead kept");
    endtask

    task automatic t_comp;
        wr(`TPWM_A_RUN, 32'h0);
        wr(`TPWM_A_OLC, 32'h43);
        wr(`TPWM_A_DEAD, 32'h2);
        wr(`TPWM_A_CYC, 32'h8);
        wr(`TPWM_A_CBUF, 32'h8);
        wr(`TPWM_A_PCMP, 32'hA);
        wr(`TPWM_A_PBUF, 32'hA);
        for (int i = 0; i < 3; i++) begin
            wr(8'(`TPWM_A_DC1 + 4 * i), 32'h4);
            wr(8'(`TPWM_A_DB1 + 4 * i), 32'h4);
        end
        wr(`TPWM_A_CNT4, 32'h0);
        wr(`TPWM_A_OME, 32'h7F);
        wr(`TPWM_A_MOD3, 32'hF);
        rdc(`TPWM_A_CNT3, 32'h2, "start at dead time");
        rdc(`TPWM_A_CNT4, 32'h0, "channel 4 start");
        bus(1'b0, `TPWM_A_SUB, 32'h0);
        h1 = int'(q);
        wr(`TPWM_A_SUB, 32'h55AA);
        rdc(`TPWM_A_SUB, 32'(h1), "subcounter read only");
        // One count clock feeds both channels, so their selects agree
        wr(`TPWM_A_RUN, 32'h3);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        // Carrier of 16 cycles; window spans ten carriers
        watch(160);
        chk({16'h0, shoot}, 32'h0, "no leg overlap");
        chk({16'h0, tog_edges}, 32'd10, "toggle per period");
        chk({31'h0, h1 > 0 && h2 > 0}, 32'h1, "phases switching");
        repeat (6) begin
            bus(1'b0, `TPWM_A_CNT3, 32'h0);
            chk({31'h0, q >= 32'h2 && q <= 32'hA}, 32'h1, "ch3 limits");
            bus(1'b0, `TPWM_A_CNT4, 32'h0);
            chk({31'h0, q <= 32'h8}, 32'h1, "ch4 limit");
        end
        wr(`TPWM_A_DB1, 32'h6);
        repeat (40) @(posedge mclk);
        rdc(`TPWM_A_DC1, 32'h4, "held until last buffer");
        wr(`TPWM_A_DB3, 32'h4);
        repeat (40) @(posedge mclk);
        rdc(`TPWM_A_DC1, 32'h6, "buffers moved together");
    endtask

    initial begin
        fails = 0;
        checked = 0;
        rst = 1'b1;
        clr = 1'b1;
        avs_address = 8'h00;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = 32'h0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        clr <= 1'b0;
        t_reset_vals();
        t_rsync();
        t_mask();
        t_comp();
        wrap_up();
    end
endmodule
`default_nettype wire
